/* verilog/bilps_pkg.sv */
// Constants and carrier types for the boot image loader and PLL setup block.
// Assumes a single 40 MHz core clock and an active-low asynchronous reset.
package bilps_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS     = 25;
  localparam int unsigned BOOT_DELAY_MIN_US = 15;
  // Least time, so round up to whole cycles
  localparam int unsigned BOOT_DELAY_CYC    =
    (BOOT_DELAY_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [9:0]  BOOT_DELAY_CNT    = 10'(BOOT_DELAY_CYC);

  // ****************************************************************
  // Boot image and CRC
  // ****************************************************************
  localparam int unsigned SECURE_BOOT_BIT = 5;
  localparam logic [31:0] CRC_POLY        = 32'hEDB8_8320;
  localparam logic [31:0] CRC_INIT        = 32'hFFFF_FFFF;
  localparam logic [31:0] CRC_SKIP        = 32'h0D15_AB1E;

  // ****************************************************************
  // PLL boot settings and clocking defaults
  // ****************************************************************
  localparam logic [11:0] PLL_F_MODE00 = 12'h09F;
  localparam logic [11:0] PLL_F_MODE11 = 12'h03F;
  localparam logic [11:0] PLL_F_MODE10 = 12'h01F;
  localparam logic [11:0] PLL_F_MODE01 = 12'h00F;
  localparam logic [2:0]  PLL_OD_BOOT  = 3'h1;
  localparam logic [5:0]  PLL_R_BOOT   = 6'h00;
  localparam logic [7:0]  REF_CLK_MHZ  = 8'h64;
  localparam logic [2:0]  CLKBLK_RESET = 3'h0;

  // ****************************************************************
  // Register map and field positions
  // ****************************************************************
  localparam logic [7:0] OFS_PLL_CFG  = 8'h00;
  localparam logic [7:0] OFS_SECURITY = 8'h04;
  localparam logic [7:0] OFS_STATUS   = 8'h08;
  localparam logic [7:0] OFS_RATIO    = 8'h0C;
  localparam logic [7:0] OFS_CRC      = 8'h10;
  localparam int unsigned POS_PLL_R   = 0;
  localparam int unsigned POS_PLL_F   = 8;
  localparam int unsigned POS_PLL_OD  = 24;
  localparam int unsigned POS_ST_STATE = 0;
  localparam int unsigned POS_ST_RUN  = 4;
  localparam int unsigned POS_ST_FAIL = 5;
  localparam int unsigned POS_ST_OTP  = 6;
  localparam int unsigned POS_ST_MODE = 8;
  localparam int unsigned POS_RAT_DEN = 16;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_DELAY, ST_LEN, ST_PROG, ST_CHECK, ST_RUN, ST_FAIL
  } bilps_state_type;

  typedef struct packed {
    logic [2:0]  pll_output_divider;
    logic [11:0] feedback;
    logic [5:0]  ref_divider;
  } bilps_pll_type;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } bilps_bus_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } bilps_byte_type;

  typedef struct packed {
    logic        we;
    logic [15:0] addr;
    logic [31:0] data;
  } bilps_ram_type;

endpackage : bilps_pkg

/* verilog/bilps_loader.sv */
// Boot loader top: delay after reset, PLL boot setup, image load and check.
// Assumes byte source, RAM and register master all run on core_clk;
// only the mode pins come from off-chip and are synchronised here.
//
// Functional notes
// RQ1 - Held in reset while rstn is low
// RQ2 - GPIO pull-downs enabled during reset
// RQ3 - Boot starts after internal post-reset delay
// RQ4 - Secure bit five selects OTP boot source
// RQ5 - Image: length, program words, check word
// RQ6 - Magic check value skips CRC verification
// RQ7 - Length and check assembled LSB first
// RQ8 - Program stored from address zero, run there
// RQ9 - CRC covers length and program bytes
// RQ10 - CRC uses reflected polynomial 0xEDB88320
// RQ11 - CRC starts all ones, result inverted
// RQ12 - Mode pins choose boot PLL feedback
// RQ13 - Tile ratio from feedback and dividers
// RQ14 - Software keeps PLL fields within range
// RQ15 - PLL fields writable at run time
// RQ16 - Board keeps mode pins static
// RQ17 - PLL clocks switch, tile, reference
// RQ18 - Reference clock defaults to 100 MHz
// RQ19 - Ports start on clock block zero
// RQ20 - Software reprograms PLL after boot
// RQ21 - CRC mismatch blocks program start
module bilps_loader
  #(parameter int unsigned RAM_AW = 16)
  (
  input  wire logic                 core_clk,
  input  wire logic                 rstn,
  input  wire logic [1:0]           mode_pin,
  input  wire logic [31:0]          otp_security,
  input  wire bilps_pkg::bilps_bus_type  bus_req,
  output logic [31:0]               bus_rdata,
  output logic                      boot_src_otp,
  output logic                      byte_ready,
  input  wire bilps_pkg::bilps_byte_type byte_in,
  output bilps_pkg::bilps_ram_type  ram_wr,
  output logic                      run,
  output logic [RAM_AW-1:0]         run_addr,
  output logic                      boot_fail,
  output logic                      gpio_pulldown,
  output bilps_pkg::bilps_pll_type  pll_cfg,
  output logic                      pll_clk_switch_en,
  output logic                      pll_clk_tile_en,
  output logic                      refclk_from_pll,
  output logic [7:0]                refclk_mhz,
  output logic [2:0]                port_clkblk
  );
  import bilps_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  bilps_state_type  state_ff, nxt_state;
  logic [9:0]       dly_ff, nxt_dly;
  logic [1:0]       bcnt_ff, nxt_bcnt;
  logic [31:0]      word_ff, nxt_word;
  logic [31:0]      len_ff, nxt_len;
  logic [31:0]      wcnt_ff, nxt_wcnt;
  logic [31:0]      crc_ff, nxt_crc;
  logic             otp_ff, nxt_otp;
  logic             ready_ff, nxt_ready;
  bilps_ram_type    ram_ff, nxt_ram;
  logic             run_ff, nxt_run;
  logic             fail_ff, nxt_fail;
  logic             pd_ff, nxt_pd;
  logic             boot_go;
  logic             take;
  logic [31:0]      asm_word;

  logic [1:0]       mode_s1_ff, mode_s2_ff, mode_s3_ff;
  logic [1:0]       nxt_mode_s1, nxt_mode_s2, nxt_mode_s3;
  logic [1:0]       mode_ff, nxt_mode;
  logic             mode_ok;
  logic [31:0]      sec_ff, nxt_sec;
  bilps_pll_type    pll_ff, nxt_pll;
  logic [31:0]      rdata_ff, nxt_rdata;
  logic [12:0]      ratio_num;
  logic [11:0]      ratio_den;

  // One byte through the reflected CRC, bit by bit
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h00_0000, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1); // see RQ10
    end
    return r;
  endfunction : crc_byte

  // ****************************************************************
  // Loader sequence
  // ****************************************************************

  // Byte accepted only while we advertise ready
  assign take     = byte_in.valid & ready_ff;
  assign asm_word = {byte_in.data, word_ff[31:8]}; // see RQ7
  // Boot may only start once the synchronised mode value is steady
  assign boot_go  = (state_ff == ST_DELAY) && (dly_ff == 10'h000) && mode_ok;

  // Next-state logic of the loader
  always_comb begin
    nxt_state = state_ff;
    nxt_dly   = dly_ff;
    nxt_bcnt  = bcnt_ff;
    nxt_word  = word_ff;
    nxt_len   = len_ff;
    nxt_wcnt  = wcnt_ff;
    nxt_crc   = crc_ff;
    nxt_otp   = otp_ff;
    nxt_ram   = ram_ff;
    nxt_ram.we = 1'b0;
    nxt_run   = run_ff;
    nxt_fail  = fail_ff;
    nxt_pd    = 1'b0; // Pull-downs end on the first clock edge after reset, see RQ2
    unique case (state_ff)
      ST_DELAY: begin
        if (dly_ff != 10'h000) begin
          nxt_dly = dly_ff - 10'h001; // see RQ3
        end else if (boot_go) begin
          nxt_otp   = sec_ff[SECURE_BOOT_BIT]; // see RQ4
          nxt_crc   = CRC_INIT; // see RQ11
          nxt_bcnt  = 2'h0;
          nxt_state = ST_LEN;
        end
      end
      ST_LEN: begin
        if (take) begin
          nxt_crc  = crc_byte(crc_ff, byte_in.data); // see RQ9
          nxt_word = asm_word;
          nxt_bcnt = bcnt_ff + 2'h1;
          if (bcnt_ff == 2'h3) begin
            nxt_len   = asm_word; // see RQ5
            nxt_wcnt  = 32'h0000_0000;
            nxt_state = (asm_word == 32'h0000_0000) ? ST_CHECK : ST_PROG;
          end
        end
      end
      ST_PROG: begin
        if (take) begin
          nxt_crc  = crc_byte(crc_ff, byte_in.data); // see RQ9
          nxt_word = asm_word;
          nxt_bcnt = bcnt_ff + 2'h1;
          if (bcnt_ff == 2'h3) begin
            // Lowest RAM address first, see RQ8
            nxt_ram.we   = 1'b1;
            nxt_ram.addr = wcnt_ff[15:0];
            nxt_ram.data = asm_word;
            nxt_wcnt     = wcnt_ff + 32'h0000_0001;
            if (wcnt_ff + 32'h0000_0001 == len_ff) begin
              nxt_state = ST_CHECK; // see RQ5
            end
          end
        end
      end
      ST_CHECK: begin
        if (take) begin
          // Check word itself stays out of the CRC
          nxt_word = asm_word;
          nxt_bcnt = bcnt_ff + 2'h1;
          if (bcnt_ff == 2'h3) begin
            if (asm_word == CRC_SKIP || asm_word == ~crc_ff) begin // see RQ6, see RQ11
              nxt_run   = 1'b1; // see RQ8
              nxt_state = ST_RUN;
            end else begin
              nxt_fail  = 1'b1; // see RQ21
              nxt_state = ST_FAIL;
            end
          end
        end
      end
      ST_RUN, ST_FAIL: begin
        nxt_state = state_ff;
      end
    endcase
    // Ready follows the state we are about to enter
    nxt_ready = (nxt_state == ST_LEN) || (nxt_state == ST_PROG) || (nxt_state == ST_CHECK);
  end

  // Loader registers; every flop forced to a constant under reset
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= ST_DELAY; // see RQ1
      dly_ff   <= BOOT_DELAY_CNT; // see RQ3
      bcnt_ff  <= 2'h0;
      word_ff  <= 32'h0000_0000;
      len_ff   <= 32'h0000_0000;
      wcnt_ff  <= 32'h0000_0000;
      crc_ff   <= CRC_INIT;
      otp_ff   <= 1'b0;
      ready_ff <= 1'b0;
      ram_ff   <= '0;
      run_ff   <= 1'b0;
      fail_ff  <= 1'b0;
      pd_ff    <= 1'b1; // see RQ2
    end else begin
      state_ff <= nxt_state;
      dly_ff   <= nxt_dly;
      bcnt_ff  <= nxt_bcnt;
      word_ff  <= nxt_word;
      len_ff   <= nxt_len;
      wcnt_ff  <= nxt_wcnt;
      crc_ff   <= nxt_crc;
      otp_ff   <= nxt_otp;
      ready_ff <= nxt_ready;
      ram_ff   <= nxt_ram;
      run_ff   <= nxt_run;
      fail_ff  <= nxt_fail;
      pd_ff    <= nxt_pd;
    end
  end

  // ****************************************************************
  // Mode pins, security word, PLL and register port
  // ****************************************************************

  // Three-stage sync; a level counts once stages two and three agree
  assign mode_ok = (mode_s2_ff == mode_s3_ff);
  // Tile ratio terms: (F+1) over 2(R+1)(OD+1)
  assign ratio_num = {1'b0, pll_ff.feedback} + 13'h0001; // see RQ13
  assign ratio_den = 12'({5'h00, pll_ff.ref_divider} + 11'h001)
                   * 12'({8'h00, pll_ff.pll_output_divider} + 12'h001) * 12'h002;

  // Next values of configuration and read data
  always_comb begin
    nxt_mode_s1 = mode_pin;
    nxt_mode_s2 = mode_s1_ff;
    nxt_mode_s3 = mode_s2_ff;
    nxt_mode    = mode_ff;
    nxt_sec     = sec_ff;
    nxt_pll     = pll_ff;
    nxt_rdata   = 32'h0000_0000;
    // Security word is static from power-up; sample it before boot
    if (state_ff == ST_DELAY) begin
      nxt_sec = otp_security;
    end
    // Mode pins are only looked at once, trusting the board to hold them
    if (boot_go) begin // see RQ16
      nxt_mode = mode_s3_ff;
      nxt_pll.pll_output_divider = PLL_OD_BOOT; // see RQ12
      nxt_pll.ref_divider        = PLL_R_BOOT;
      unique case (mode_s3_ff)
        2'b00: nxt_pll.feedback = PLL_F_MODE00;
        2'b11: nxt_pll.feedback = PLL_F_MODE11;
        2'b10: nxt_pll.feedback = PLL_F_MODE10;
        2'b01: nxt_pll.feedback = PLL_F_MODE01;
      endcase
    end else if (bus_req.wr && bus_req.addr == OFS_PLL_CFG) begin
      // Each field takes only the low bits of its slice, with no range check, see RQ14
      nxt_pll.ref_divider        = bus_req.wdata[POS_PLL_R +: 6]; // see RQ15
      nxt_pll.feedback           = bus_req.wdata[POS_PLL_F +: 12]; // see RQ15, see RQ20
      nxt_pll.pll_output_divider = bus_req.wdata[POS_PLL_OD +: 3]; // see RQ15
    end
    // Read data for the cycle after the strobe; unmapped reads give zero
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        OFS_PLL_CFG: begin
          nxt_rdata[POS_PLL_R +: 6]  = pll_ff.ref_divider;
          nxt_rdata[POS_PLL_F +: 12] = pll_ff.feedback;
          nxt_rdata[POS_PLL_OD +: 3] = pll_ff.pll_output_divider;
        end
        OFS_SECURITY: nxt_rdata = sec_ff;
        OFS_STATUS: begin
          nxt_rdata[POS_ST_STATE +: 3] = state_ff;
          nxt_rdata[POS_ST_RUN]        = run_ff;
          nxt_rdata[POS_ST_FAIL]       = fail_ff;
          nxt_rdata[POS_ST_OTP]        = otp_ff;
          nxt_rdata[POS_ST_MODE +: 2]  = mode_ff;
        end
        OFS_RATIO: begin
          nxt_rdata[12:0]               = ratio_num;
          nxt_rdata[POS_RAT_DEN +: 12]  = ratio_den;
        end
        OFS_CRC: nxt_rdata = ~crc_ff;
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  // Configuration registers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      mode_s1_ff <= 2'b00;
      mode_s2_ff <= 2'b00;
      mode_s3_ff <= 2'b00;
      mode_ff    <= 2'b00;
      sec_ff     <= 32'h0000_0000;
      pll_ff     <= '{PLL_OD_BOOT, PLL_F_MODE00, PLL_R_BOOT};
      rdata_ff   <= 32'h0000_0000;
    end else begin
      mode_s1_ff <= nxt_mode_s1;
      mode_s2_ff <= nxt_mode_s2;
      mode_s3_ff <= nxt_mode_s3;
      mode_ff    <= nxt_mode;
      sec_ff     <= nxt_sec;
      pll_ff     <= nxt_pll;
      rdata_ff   <= nxt_rdata;
    end
  end

  // ****************************************************************
  // Clock routing flags
  // ****************************************************************
  logic sw_en_ff, tile_en_ff, ref_src_ff;
  logic [7:0] ref_mhz_ff;
  logic [2:0] clkblk_ff;

  // Routing is fixed here; the PLL feeds everything from the first edge
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sw_en_ff   <= 1'b0;
      tile_en_ff <= 1'b0;
      ref_src_ff <= 1'b0;
      ref_mhz_ff <= REF_CLK_MHZ; // see RQ18
      clkblk_ff  <= CLKBLK_RESET; // see RQ19
    end else begin
      sw_en_ff   <= 1'b1; // see RQ17
      tile_en_ff <= 1'b1; // see RQ17
      ref_src_ff <= 1'b1; // see RQ17
      ref_mhz_ff <= REF_CLK_MHZ;
      clkblk_ff  <= CLKBLK_RESET;
    end
  end

  // Outputs straight from flops, except run_addr, which is a constant
  assign bus_rdata         = rdata_ff;
  assign boot_src_otp      = otp_ff;
  assign byte_ready        = ready_ff;
  assign ram_wr            = ram_ff;
  assign run               = run_ff;
  assign run_addr          = '0; // Constant start address, see RQ8
  assign boot_fail         = fail_ff;
  assign gpio_pulldown     = pd_ff;
  assign pll_cfg           = pll_ff;
  assign pll_clk_switch_en = sw_en_ff;
  assign pll_clk_tile_en   = tile_en_ff;
  assign refclk_from_pll   = ref_src_ff;
  assign refclk_mhz        = ref_mhz_ff;
  assign port_clkblk       = clkblk_ff;

endmodule : bilps_loader

/* tb/bilps_loader_props.sv */
// Checker for the boot loader: boot timing, outcome and PLL setup.
// Assumes it is bound into bilps_loader and sees only its ports.
module bilps_loader_props
  #(parameter int unsigned RAM_AW = 16)
  (
  input wire logic                     core_clk,
  input wire logic                     rstn,
  input wire logic [1:0]               mode_pin,
  input wire logic [31:0]              otp_security,
  input wire bilps_pkg::bilps_bus_type bus_req,
  input wire logic                     boot_src_otp,
  input wire logic                     byte_ready,
  input wire bilps_pkg::bilps_ram_type ram_wr,
  input wire logic                     run,
  input wire logic [RAM_AW-1:0]        run_addr,
  input wire logic                     boot_fail,
  input wire logic                     gpio_pulldown,
  input wire bilps_pkg::bilps_pll_type pll_cfg,
  input wire logic                     pll_clk_switch_en,
  input wire logic                     pll_clk_tile_en,
  input wire logic                     refclk_from_pll
  );
  import bilps_pkg::*;
  localparam int DLY = 600;
  // ****************************************
  // Helper counters
  // ****************************************
  logic [9:0]  cnt_ff, nxt_cnt;
  logic [15:0] wcnt_ff, nxt_wcnt;
  // Saturates so a long run never wraps into the delay window
  always_comb begin
    nxt_cnt  = (cnt_ff == 10'h3ff) ? cnt_ff : cnt_ff + 10'h001;
    nxt_wcnt = ram_wr.we ? wcnt_ff + 16'h0001 : wcnt_ff;
  end
  // Cleared by every reset, like the loader itself
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_ff  <= '0;
      wcnt_ff <= '0;
    end else begin
      cnt_ff  <= nxt_cnt;
      wcnt_ff <= nxt_wcnt;
    end
  end
  // Boot feedback per strap pair
  function automatic logic [11:0] fb_of(input logic [1:0] m);
    case (m)
      2'b00:   return 12'h09f;
      2'b11:   return 12'h03f;
      2'b10:   return 12'h01f;
      default: return 12'h00f;
    endcase
  endfunction : fb_of
  // ****************************************
  // Properties
  // ****************************************
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  sequence s_boot_go;
    $rose(byte_ready);
  endsequence
  sequence s_boot_end;
    $fell(byte_ready);
  endsequence
  a_no_early_ready: assert property (byte_ready |-> cnt_ff >= DLY)
    else $error("byte ready before boot delay");
  a_boot_source: assert property (s_boot_go |-> boot_src_otp == otp_security[5])
    else $error("wrong boot source");
  a_boot_pll: assert property (s_boot_go |-> pll_cfg == {3'h1, fb_of(mode_pin), 6'h00})
    else $error("wrong boot pll setting");
  a_end_result: assert property (s_boot_end |-> run != boot_fail)
    else $error("image end without one outcome");
  a_run_start: assert property ($rose(run) |-> run_addr == '0 && !boot_fail)
    else $error("program start not at zero");
  a_run_sticky: assert property (run |=> run && !boot_fail)
    else $error("run dropped");
  a_fail_blocks: assert property (boot_fail |-> !run)
    else $error("run after check mismatch");
  a_word_pulse: assert property (ram_wr.we |=> !ram_wr.we [*3])
    else $error("word writes closer than four bytes");
  a_ram_addr: assert property (ram_wr.we |-> ram_wr.addr == wcnt_ff)
    else $error("ram address not word index");
  a_pll_write: assert property (bus_req.wr && bus_req.addr == 8'h00 && run |=>
    pll_cfg == {$past(bus_req.wdata[26:24]), $past(bus_req.wdata[19:8]),
    $past(bus_req.wdata[5:0])})
    else $error("pll write not applied");
  a_pulldown_off: assert property ($past(rstn) |-> !gpio_pulldown)
    else $error("pull-down left on");
  a_clk_enables: assert property ($past(rstn) |->
    pll_clk_tile_en && pll_clk_switch_en && refclk_from_pll)
    else $error("pll clock outputs off");
endmodule : bilps_loader_props

bind bilps_loader bilps_loader_props #(.RAM_AW(RAM_AW)) u_props (.core_clk, .rstn,
  .mode_pin, .otp_security, .bus_req, .boot_src_otp, .byte_ready, .ram_wr, .run,
  .run_addr, .boot_fail, .gpio_pulldown, .pll_cfg, .pll_clk_switch_en,
  .pll_clk_tile_en, .refclk_from_pll);

/* tb/bilps_flash_model.sv */
// Byte source standing in for the boot flash or OTP behind the loader.
// Assumes the bench fills mem and n_bytes; gap sets idle cycles per byte.
module bilps_flash_model
  (
  input  wire logic                 core_clk,
  input  wire logic                 rstn,
  input  wire logic                 byte_ready,
  input  wire logic [1:0]           gap,
  output bilps_pkg::bilps_byte_type byte_in
  );
  import bilps_pkg::*;
  logic [7:0]     mem [0:31];
  int unsigned    n_bytes;
  logic [5:0]     idx_ff, nxt_idx;
  logic [1:0]     wait_ff, nxt_wait;
  bilps_byte_type out_ff, nxt_out;
  assign byte_in = out_ff;
  // Hold each byte until taken, then stall for gap cycles
  always_comb begin
    nxt_idx  = idx_ff;
    nxt_wait = wait_ff;
    nxt_out  = out_ff;
    if (out_ff.valid && byte_ready) begin
      nxt_idx       = idx_ff + 6'h01;
      nxt_wait      = gap;
      nxt_out.valid = 1'b0;
    end else if (wait_ff != 2'h0) begin
      nxt_wait = wait_ff - 2'h1;
    end
    // Idle data toggles so no stale byte can pass for a fresh one
    if (!nxt_out.valid) begin
      nxt_out.data = ~out_ff.data;
      if (nxt_wait == 2'h0 && nxt_idx < n_bytes) begin
        nxt_out.valid = 1'b1;
        nxt_out.data  = mem[nxt_idx];
      end
    end
  end
  // Stream restarts at byte zero on every reset
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      idx_ff  <= '0;
      wait_ff <= '0;
      out_ff  <= '0;
    end else begin
      idx_ff  <= nxt_idx;
      wait_ff <= nxt_wait;
      out_ff  <= nxt_out;
    end
  end
endmodule : bilps_flash_model

/* tb/bilps_loader_tb.sv */
// Bench for the boot loader: four boots, one per strap pair; three run and one fails its check.
// Assumes the byte model answers on byte_ready and the checker is bound.
module bilps_loader_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import bilps_pkg::*;
  logic core_clk, rstn, boot_src_otp, byte_ready, run, boot_fail, gpio_pulldown;
  logic pll_clk_switch_en, pll_clk_tile_en, refclk_from_pll;
  logic [1:0]  mode_pin, gap;
  logic [31:0] otp_security, bus_rdata, crc;
  logic [15:0] run_addr;
  logic [7:0]  refclk_mhz;
  logic [2:0]  port_clkblk;
  bilps_bus_type  bus_req;
  bilps_byte_type byte_in;
  bilps_ram_type  ram_wr;
  bilps_pll_type  pll_cfg;
  logic [31:0] got_w [0:7];
  logic [15:0] got_a [0:7];
  int nw, mismatches, n_tests;
  logic [1:0]  modes [4] = '{2'b00, 2'b11, 2'b10, 2'b01};
  logic [11:0] fbs [4] = '{12'h09f, 12'h03f, 12'h01f, 12'h00f};
  bilps_loader u_dut (.core_clk, .rstn, .mode_pin, .otp_security, .bus_req,
    .bus_rdata, .boot_src_otp, .byte_ready, .byte_in, .ram_wr, .run, .run_addr,
    .boot_fail, .gpio_pulldown, .pll_cfg, .pll_clk_switch_en, .pll_clk_tile_en,
    .refclk_from_pll, .refclk_mhz, .port_clkblk);
  bilps_flash_model u_flash (.core_clk, .rstn, .byte_ready, .gap, .byte_in);
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    bus_req <= {1'b1, 1'b0, a, d};
    @(posedge core_clk);
    bus_req <= '0;
    #1;
  endtask : wr_reg
  // Read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    bus_req <= {1'b0, 1'b1, a, 32'h0000_0000};
    @(posedge core_clk);
    bus_req <= '0;
    #1;
    d = bus_rdata;
  endtask : rd_reg
  // Reflected update, one byte, low bit first
  function automatic logic [31:0] crc_upd(input logic [31:0] c, input logic [7:0] b);
    c = c ^ {24'h00_0000, b};
    for (int j = 0; j < 8; j++) c = c[0] ? (c >> 1) ^ 32'hedb8_8320 : c >> 1;
    return c;
  endfunction : crc_upd
  task automatic add_word(input logic [31:0] w, input bit crc_on);
    for (int b = 0; b < 4; b++) begin
      u_flash.mem[u_flash.n_bytes] = w[8*b +: 8];
      if (crc_on) crc = crc_upd(crc, w[8*b +: 8]);
      u_flash.n_bytes++;
    end
  endtask : add_word
  // One full boot: reset, image, outcome and register view
  task automatic boot(input int i);
    logic [31:0] v, len, st;
    int k;
    @(posedge core_clk);
    rstn <= 1'b0;
    mode_pin <= modes[i];
    otp_security <= (i % 2) ? 32'h0000_0020 : 32'h0000_0000;
    gap <= 2'(i);
    nw = 0;
    u_flash.n_bytes = 0;
    crc = 32'hffff_ffff;
    len = (i == 0) ? 2 : (i == 3) ? 0 : 1;
    add_word(len, 1);
    for (k = 0; k < len; k++) add_word({16'hc0de, 8'(i), 8'(k)}, 1);
    add_word((i == 1) ? CRC_SKIP : (i == 2) ? ~crc ^ 32'h0000_0001 : ~crc, 0);
    repeat (6) @(posedge core_clk);
    #1;
    chk(32'({gpio_pulldown, byte_ready, run}), 32'h0000_0004, "reset state");
    chk(32'({refclk_mhz, port_clkblk}), 32'h0000_0320, "ref clock");
    chk(32'(pll_cfg), 32'({3'h1, 12'h09f, 6'h00}), "reset pll");
    @(posedge core_clk);
    rstn <= 1'b1;
    // Look just after each edge so the flop output has settled
    for (k = 0; k < 700 && byte_ready !== 1'b1; k++) begin
      @(posedge core_clk);
      #1;
    end
    chk(32'(k >= 600 && k <= 604), 32'h0000_0001, "boot delay");
    for (k = 0; k < 3000 && run !== 1'b1 && boot_fail !== 1'b1; k++) begin
      @(posedge core_clk);
      #1;
    end
    chk(32'({run, boot_fail}), (i == 2) ? 32'h0000_0001 : 32'h0000_0002, "outcome");
    chk(32'(run_addr), 32'h0000_0000, "run addr");
    chk(32'(boot_src_otp), 32'(i % 2), "boot source");
    chk(32'(nw), len, "word count");
    for (k = 0; k < len; k++) begin
      chk(got_w[k], {16'hc0de, 8'(i), 8'(k)}, "ram data");
      chk(32'(got_a[k]), 32'(k), "ram addr");
    end
    chk(32'(pll_cfg), 32'({3'h1, fbs[i], 6'h00}), "boot pll");
    rd_reg(OFS_RATIO, v);
    chk(v, {4'h0, 12'h004, 3'h0, 13'(fbs[i] + 12'h001)}, "ratio");
    st = {22'h00_0000, modes[i], 1'b0, 1'(i % 2), 1'(i == 2), 1'(i != 2), 1'b0,
      (i == 2) ? 3'h5 : 3'h4};
    rd_reg(OFS_STATUS, v);
    chk(v, st, "status");
    rd_reg(OFS_SECURITY, v);
    chk(v, (i % 2) ? 32'h0000_0020 : 32'h0000_0000, "security word");
    rd_reg(OFS_CRC, v);
    chk(v, ~crc, "crc value");
    if (i == 0) begin
      wr_reg(OFS_PLL_CFG, 32'h0300_c701);
      chk(32'(pll_cfg), 32'({3'h3, 12'h0c7, 6'h01}), "pll write");
      rd_reg(OFS_RATIO, v);
      chk(v, 32'h0010_00c8, "new ratio");
      wr_reg(OFS_STATUS, 32'h0000_0000);
      rd_reg(OFS_STATUS, v);
      chk(v, st, "status read only");
      rd_reg(8'h20, v);
      chk(v, 32'h0000_0000, "unmapped read");
    end
  endtask : boot
  task automatic complete_run();
    $display("mismatches %0d n_tests %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run
  // ****************************************
  // Clock, monitor, sequence, watchdog
  // ****************************************
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // Captures every program word; mid-cycle, clear of the launching edge
  always @(negedge core_clk) begin
    if (ram_wr.we === 1'b1 && nw < 8) begin
      got_w[nw] = ram_wr.data;
      got_a[nw] = ram_wr.addr;
      nw++;
    end
  end
  // Each boot after the first also resets the loader out of the previous boot's run or fail state
  initial begin
    rstn = 1'b0;
    mode_pin = 2'b00;
    otp_security = 32'h0000_0000;
    bus_req = '0;
    gap = 2'h0;
    for (int i = 0; i < 4; i++) boot(i);
    complete_run();
  end
  // Four boots need about 2600 cycles; 20000 cycles, over seven times that, is a hang
  initial begin
    #(25 * 20000);
    mismatches++;
    complete_run();
  end
endmodule : bilps_loader_tb
